// ---- rtl/ela_map.svh ----
/*
 * Register offsets, field positions, reset values and timing counts of the
 * embedded logic-analyzer trigger core.
 * Assumes it is included by its bare name from the rtl folder.
 */
`ifndef ELA_MAP_SVH
`define ELA_MAP_SVH

`define ELA_OFS_CTRL 8'h00
`define ELA_OFS_STATUS 8'h04
`define ELA_OFS_COND 8'h08
`define ELA_OFS_STIM_SEL 8'h0C
`define ELA_OFS_STIM_DATA 8'h10
`define ELA_OFS_RD_SEL 8'h14
`define ELA_OFS_RD_DATA 8'h18
`define ELA_OFS_START 8'h1C

`define ELA_CTRL_ARM 0
`define ELA_CTRL_REPEAT 1
`define ELA_CTRL_PRE_LO 2
`define ELA_CTRL_NCOND_LO 4
`define ELA_CTRL_AND_LO 8
`define ELA_CTRL_ACK 12

`define ELA_COND_BIT_LO 0
`define ELA_COND_SEL_LO 8
`define ELA_COND_CODE_LO 16

`define ELA_STAT_STATE_LO 0
`define ELA_STAT_CIDX_LO 8

`define ELA_RDSEL_SMP_LO 0
`define ELA_RDSEL_WORD_LO 16

`define ELA_NCOND_RST 2'h1
`define ELA_PRE_RST 2'h0
`define ELA_TRIG_OUT_LAG 3'h5
`define ELA_ARM_DELAY_DEF 16'h0010
`define ELA_RD_WAIT 2'h2

`endif

// ---- rtl/ela_pkg.sv ----
/*
 * Types shared by the trigger core and its condition evaluator.
 * Assumes nothing of its surroundings.
 */
package ela_pkg;

	typedef enum logic [4:0] {
		ST_IDLE = 5'h01,
		ST_ARMING = 5'h02,
		ST_ARMED = 5'h04,
		ST_TRIGGERED = 5'h08,
		ST_DONE = 5'h10
	} cap_state_e;

	typedef enum logic [2:0] {
		BC_DONT_CARE = 3'h0,
		BC_LEVEL0 = 3'h1,
		BC_LEVEL1 = 3'h2,
		BC_RISE = 3'h3,
		BC_FALL = 3'h4
	} bit_cond_e;

endpackage: ela_pkg

// ---- rtl/ela_cond_if.sv ----
/*
 * Interface between the trigger core and one condition evaluator.
 * Assumes the core drives samples and codes, the evaluator the match.
 */
`timescale 1ns/1ns
`default_nettype none

interface ela_cond_if #(
	parameter int W = 40
);
	logic [W-1:0] cur;
	logic [W-1:0] prev;
	logic [W-1:0][2:0] code;
	logic and_mode;
	logic match;

	modport eval(input cur, input prev, input code, input and_mode, output match);
	modport core(output cur, output prev, output code, output and_mode, input match);
endinterface: ela_cond_if

`default_nettype wire

// ---- rtl/ela_cond_match.sv ----
/*
 * Combinational evaluator of one trigger condition over the trigger bits.
 * Assumes cur and prev are two consecutive registered samples.
 */
`timescale 1ns/1ns
`default_nettype none

module ela_cond_match #(
	parameter int W = 40
) (
	ela_cond_if.eval cif
);
	logic [W-1:0] hit;
	logic [W-1:0] used;

	always_comb begin
		hit = '0;
		used = '0;
		for (int i = 0; i < W; i++) begin
			unique case (cif.code[i])
				ela_pkg::BC_DONT_CARE: begin
					used[i] = 1'b0;
				end
				ela_pkg::BC_LEVEL0: begin
					used[i] = 1'b1;
					hit[i] = ~cif.cur[i];
				end
				ela_pkg::BC_LEVEL1: begin
					used[i] = 1'b1;
					hit[i] = cif.cur[i];
				end
				ela_pkg::BC_RISE: begin
					used[i] = 1'b1;
					hit[i] = cif.cur[i] & ~cif.prev[i];
				end
				ela_pkg::BC_FALL: begin
					used[i] = 1'b1;
					hit[i] = ~cif.cur[i] & cif.prev[i];
				end
				default: begin
					used[i] = 1'b0;
				end
			endcase
		end
	end

	// all don't-care is always true
	assign cif.match = ~|used | (cif.and_mode ? &(hit | ~used) : |(hit & used));

endmodule: ela_cond_match

`default_nettype wire

// ---- rtl/ela_trigger_core.sv ----
/*
 * Embedded logic-analyzer capture core: probe sampling, sequential trigger,
 * circular capture buffer, stimulus outputs and an AHB-Lite register slave.
 * Assumes CLK_SYS_IN is well above twice the user clock rate, DEPTH is a power
 * of two, STIM_W is at least one and PROBE_W >= TRIG_W when triggering from
 * the probe bus.
 */
`timescale 1ns/1ns
`default_nettype none
`include "ela_map.svh"

module ela_trigger_core #(
	parameter int PROBE_W = 40,
	parameter int DEPTH = 1024,
	parameter int TRIG_W = 40,
	parameter int NUM_COND = 3,
	parameter bit TRIG_FROM_PROBE = 1'b1,
	parameter int STIM_W = 20,
	parameter int INPUT_STAGE_COUNT = 3,
	parameter logic [15:0] ARM_DELAY = `ELA_ARM_DELAY_DEF,
	parameter bit INIT_EN = 1'b0,
	parameter logic [TRIG_W*3-1:0] INIT_CODES = '0,
	parameter bit INIT_AND = 1'b1
) (
	input wire logic CLK_SYS_IN,
	input wire logic RST_B_IN,
	input wire logic USER_CLK_IN,
	input wire logic [PROBE_W-1:0] PROBE_IN,
	input wire logic [TRIG_W-1:0] TRIG_IN,
	output logic [STIM_W-1:0] STIM_OUT,
	output logic STIM_VALID_OUT,
	output logic ARMED_OUT,
	output logic TRIG_OUT,
	input wire logic HSEL_IN,
	input wire logic [31:0] HADDR_IN,
	input wire logic [1:0] HTRANS_IN,
	input wire logic HWRITE_IN,
	input wire logic [2:0] HSIZE_IN,
	input wire logic [31:0] HWDATA_IN,
	input wire logic HREADY_IN,
	output logic HREADYOUT_OUT,
	output logic [31:0] HRDATA_OUT,
	output logic HRESP_OUT
);
	localparam int AW = $clog2(DEPTH);
	localparam int QTR = DEPTH / 4;
	localparam int N = INPUT_STAGE_COUNT;

	typedef struct packed {
		ela_pkg::cap_state_e st;
		logic [2:0] uclk;
		logic [PROBE_W-1:0] probe_s1;
		logic [PROBE_W-1:0] probe_s2;
		logic [TRIG_W-1:0] trig_s1;
		logic [TRIG_W-1:0] trig_s2;
		logic [N:0][PROBE_W-1:0] ppipe;
		logic [N:0][TRIG_W-1:0] tpipe;
		logic smp_vld;
		logic [TRIG_W-1:0] prev_trig;
		logic [NUM_COND-1:0][TRIG_W-1:0][2:0] codes;
		logic [2:0] and_mode;
		logic [1:0] ncond;
		logic [1:0] pre_qtr;
		logic repeat_en;
		logic arm_req;
		logic ack_req;
		logic init_pend;
		logic [STIM_W-1:0] stim_shadow;
		logic [STIM_W-1:0] stim;
		logic [7:0] stim_sel;
		logic [AW-1:0] rd_smp;
		logic [6:0] rd_word;
		logic [1:0] cidx;
		logic [AW-1:0] wr_ptr;
		logic [AW-1:0] start_addr;
		logic [AW:0] post_left;
		logic [15:0] dly;
		logic [2:0] ext_cnt;
		logic ext_run;
		logic ext_trig;
		logic wr_pend;
		logic [1:0] rd_wait;
		logic ph_map;
		logic [7:0] ph_addr;
		logic [31:0] hrdata;
	} core_s;

	core_s q;
	core_s d;
	logic [NUM_COND-1:0] cmatch;
	logic mem_we;
	logic [PROBE_W-1:0] mem [DEPTH];
	logic [PROBE_W-1:0] mem_rd_q;

	for (genvar g = 0; g < NUM_COND; g++) begin : g_cond
		ela_cond_if #(.W(TRIG_W)) cif();
		// evaluated only on registered samples
		assign cif.cur = q.tpipe[N];
		assign cif.prev = q.prev_trig;
		assign cif.code = q.codes[g];
		assign cif.and_mode = q.and_mode[g];
		assign cmatch[g] = cif.match;
		ela_cond_match #(.W(TRIG_W)) u_match (
			.cif(cif.eval)
		);
	end

	assign mem_we = q.smp_vld & (q.st == ela_pkg::ST_ARMED || q.st == ela_pkg::ST_TRIGGERED);

	always_ff @(posedge CLK_SYS_IN) begin
		if (mem_we) begin
			mem[q.wr_ptr] <= q.ppipe[N];
		end
		mem_rd_q <= mem[q.rd_smp];
	end

	always_comb begin
		logic rise;
		logic [AW:0] pre_len;
		logic [1:0] lastc;
		logic [31:0] rv;
		int idx;
		d = q;
		rise = q.uclk[1] & ~q.uclk[2];
		pre_len = (AW+1)'(q.pre_qtr) * (AW+1)'(QTR);
		lastc = (q.ncond <= 2'h1) ? 2'h0 : q.ncond - 2'h1;
		if (int'(lastc) > NUM_COND - 1) begin
			lastc = 2'(NUM_COND - 1);
		end
		rv = '0;
		idx = 0;

		// two-flop synchronisers; first stage feeds only the second
		d.uclk = {q.uclk[1:0], USER_CLK_IN};
		d.probe_s1 = PROBE_IN;
		d.probe_s2 = q.probe_s1;
		d.trig_s1 = TRIG_IN;
		d.trig_s2 = q.trig_s1;

		// one sample per user clock rising edge
		d.smp_vld = rise;
		if (rise) begin
			d.ppipe[0] = q.probe_s2;
			d.tpipe[0] = TRIG_FROM_PROBE ? q.probe_s2[TRIG_W-1:0] : q.trig_s2;
			for (int i = 1; i <= N; i++) begin
				d.ppipe[i] = q.ppipe[i-1];
				d.tpipe[i] = q.tpipe[i-1];
			end
		end
		if (q.smp_vld) begin
			d.prev_trig = q.tpipe[N];
		end

		if (q.ext_run & rise) begin
			if (q.ext_cnt == `ELA_TRIG_OUT_LAG - 3'h1) begin
				d.ext_trig = 1'b1;
				d.ext_run = 1'b0;
			end else begin
				d.ext_cnt = q.ext_cnt + 3'h1;
			end
		end

		unique case (q.st)
			ela_pkg::ST_IDLE: begin
				if (q.arm_req | q.init_pend) begin
					d.arm_req = 1'b0;
					d.init_pend = 1'b0;
					d.ack_req = 1'b0;
					d.st = ela_pkg::ST_ARMING;
					d.stim = q.stim_shadow;
					d.dly = '0;
					d.cidx = '0;
					d.wr_ptr = '0;
					d.ext_run = 1'b0;
					d.ext_trig = 1'b0;
				end
			end
			ela_pkg::ST_ARMING: begin
				d.dly = q.dly + 16'h0001;
				if (q.dly + 16'h0001 >= ARM_DELAY) begin
					d.st = ela_pkg::ST_ARMED;
				end
			end
			ela_pkg::ST_ARMED: begin
				if (q.arm_req) begin
					d.st = ela_pkg::ST_IDLE;
				end else if (q.smp_vld) begin
					d.wr_ptr = q.wr_ptr + AW'(1);
					if (cmatch[q.cidx]) begin
						if (q.cidx >= lastc) begin
							d.st = ela_pkg::ST_TRIGGERED;
							d.start_addr = q.wr_ptr - pre_len[AW-1:0];
							d.post_left = (AW+1)'(DEPTH - 1) - pre_len;
							d.ext_run = 1'b1;
							d.ext_cnt = '0;
						end else begin
							d.cidx = q.cidx + 2'h1;
						end
					end
				end
			end
			ela_pkg::ST_TRIGGERED: begin
				if (q.arm_req) begin
					d.st = ela_pkg::ST_IDLE;
				end else if (q.smp_vld) begin
					d.wr_ptr = q.wr_ptr + AW'(1);
					d.post_left = q.post_left - (AW+1)'(1);
					if (q.post_left == (AW+1)'(1)) begin
						d.st = ela_pkg::ST_DONE;
					end
				end
			end
			ela_pkg::ST_DONE: begin
				if (q.arm_req) begin
					d.st = ela_pkg::ST_IDLE;
				end else if (q.repeat_en & q.ack_req) begin
					d.ack_req = 1'b0;
					d.arm_req = 1'b1;
					d.st = ela_pkg::ST_IDLE;
				end
			end
			default: begin
				d.st = ela_pkg::ST_IDLE;
			end
		endcase

		// bus write data phase; a set here wins over the clears above
		if (q.wr_pend) begin
			d.wr_pend = 1'b0;
			if (q.ph_map) begin
				unique case (q.ph_addr)
					`ELA_OFS_CTRL: begin
						if (HWDATA_IN[`ELA_CTRL_ARM]) begin
							d.arm_req = 1'b1;
						end
						if (HWDATA_IN[`ELA_CTRL_ACK]) begin
							d.ack_req = 1'b1;
						end
						d.repeat_en = HWDATA_IN[`ELA_CTRL_REPEAT];
						d.pre_qtr = HWDATA_IN[`ELA_CTRL_PRE_LO +: 2];
						d.ncond = HWDATA_IN[`ELA_CTRL_NCOND_LO +: 2];
						d.and_mode = HWDATA_IN[`ELA_CTRL_AND_LO +: 3];
					end
					`ELA_OFS_COND: begin
						for (int c = 0; c < NUM_COND; c++) begin
							for (int b = 0; b < TRIG_W; b++) begin
								if (int'(HWDATA_IN[`ELA_COND_SEL_LO +: 2]) == c &&
									int'(HWDATA_IN[`ELA_COND_BIT_LO +: 6]) == b) begin
									d.codes[c][b] = HWDATA_IN[`ELA_COND_CODE_LO +: 3];
								end
							end
						end
					end
					`ELA_OFS_STIM_SEL: begin
						d.stim_sel = HWDATA_IN[7:0];
					end
					`ELA_OFS_STIM_DATA: begin
						for (int i = 0; i < STIM_W; i++) begin
							if (i / 32 == int'(q.stim_sel)) begin
								d.stim_shadow[i] = HWDATA_IN[i % 32];
							end
						end
					end
					`ELA_OFS_RD_SEL: begin
						d.rd_smp = HWDATA_IN[`ELA_RDSEL_SMP_LO +: AW];
						d.rd_word = HWDATA_IN[`ELA_RDSEL_WORD_LO +: 7];
					end
					default: begin
					end
				endcase
			end
		end

		// read data phase: two wait states so the buffer read settles
		if (q.rd_wait != 2'h0) begin
			d.rd_wait = q.rd_wait - 2'h1;
			if (q.rd_wait == 2'h1 && q.ph_map) begin
				unique case (q.ph_addr)
					`ELA_OFS_CTRL: begin
						rv[`ELA_CTRL_REPEAT] = q.repeat_en;
						rv[`ELA_CTRL_PRE_LO +: 2] = q.pre_qtr;
						rv[`ELA_CTRL_NCOND_LO +: 2] = q.ncond;
						rv[`ELA_CTRL_AND_LO +: 3] = q.and_mode;
					end
					`ELA_OFS_STATUS: begin
						rv[`ELA_STAT_STATE_LO +: 5] = q.st;
						rv[`ELA_STAT_CIDX_LO +: 2] = q.cidx;
					end
					`ELA_OFS_STIM_SEL: begin
						rv[7:0] = q.stim_sel;
					end
					`ELA_OFS_STIM_DATA: begin
						for (int i = 0; i < 32; i++) begin
							idx = int'(q.stim_sel) * 32 + i;
							if (idx < STIM_W) begin
								rv[i] = q.stim_shadow[idx];
							end
						end
					end
					`ELA_OFS_RD_SEL: begin
						rv[`ELA_RDSEL_SMP_LO +: AW] = q.rd_smp;
						rv[`ELA_RDSEL_WORD_LO +: 7] = q.rd_word;
					end
					`ELA_OFS_RD_DATA: begin
						for (int i = 0; i < 32; i++) begin
							idx = int'(q.rd_word) * 32 + i;
							if (idx < PROBE_W) begin
								rv[i] = mem_rd_q[idx];
							end
						end
					end
					`ELA_OFS_START: begin
						rv[AW-1:0] = q.start_addr;
					end
					default: begin
					end
				endcase
			end
			if (q.rd_wait == 2'h1) begin
				d.hrdata = rv;
			end
		end

		// answers only when selected, leaving the port free for others
		if (HSEL_IN & HTRANS_IN[1] & HREADY_IN) begin
			d.ph_map = (HADDR_IN[31:8] == 24'h00_0000);
			d.ph_addr = HADDR_IN[7:0];
			d.wr_pend = HWRITE_IN;
			d.rd_wait = HWRITE_IN ? 2'h0 : `ELA_RD_WAIT;
		end

		if (!RST_B_IN) begin
			d = '0;
			d.st = ela_pkg::ST_IDLE;
			d.codes[0] = INIT_CODES;
			d.and_mode[0] = INIT_AND;
			d.ncond = `ELA_NCOND_RST;
			d.pre_qtr = `ELA_PRE_RST;
			d.init_pend = INIT_EN;
		end
	end

	always_ff @(posedge CLK_SYS_IN) begin
		q <= d;
	end

	assign STIM_OUT = q.stim;
	assign STIM_VALID_OUT = (q.st != ela_pkg::ST_IDLE);
	assign ARMED_OUT = (q.st == ela_pkg::ST_ARMED) | (q.st == ela_pkg::ST_TRIGGERED);
	assign TRIG_OUT = q.ext_trig;
	assign HREADYOUT_OUT = (q.rd_wait == 2'h0);
	assign HRDATA_OUT = q.hrdata;
	assign HRESP_OUT = 1'b0;

endmodule: ela_trigger_core

`default_nettype wire

// ---- verification/user_side_model.sv ----
/*
 * User-side model: a free-running user clock and a counting probe bus.
 * Assumes the core samples the probe on rising user clock edges.
 */
`timescale 1ns/1ns
`default_nettype none

module user_side_model (
	output logic user_clk_out,
	output logic [7:0] probe_out,
	output logic [7:0] trig_out
);
	// phase unrelated to the system clock; probe steps on the falling
	// edge so rising edges see settled data
	initial begin
		user_clk_out = 1'b0;
		probe_out = 8'h00;
		#137;
		forever begin
			#200 user_clk_out = 1'b1;
			#200 user_clk_out = 1'b0;
			probe_out = probe_out + 8'h01;
		end
	end

	// ignored by the core when triggering from the probe bus
	assign trig_out = ~probe_out;
endmodule: user_side_model

`default_nettype wire

// ---- verification/ela_trigger_chk.sv ----
/*
 * Port-level assertions for the trigger core.
 * Assumes the single system clock domain with synchronous low reset.
 */
`timescale 1ns/1ns
`default_nettype none

module ela_trigger_chk #(
	parameter int STIM_W = 20,
	parameter logic [15:0] ARM_DELAY = 16'h0010
) (
	input wire logic CLK_SYS_IN,
	input wire logic RST_B_IN,
	input wire logic [STIM_W-1:0] STIM_OUT,
	input wire logic STIM_VALID_OUT,
	input wire logic ARMED_OUT,
	input wire logic TRIG_OUT,
	input wire logic HSEL_IN,
	input wire logic [1:0] HTRANS_IN,
	input wire logic HWRITE_IN,
	input wire logic HREADY_IN,
	input wire logic HREADYOUT_OUT,
	input wire logic [31:0] HRDATA_OUT,
	input wire logic HRESP_OUT
);
	logic [15:0] vcnt_q;
	logic [15:0] vcnt_d;
	logic take;

	assign take = HSEL_IN && HTRANS_IN[1] && HREADY_IN;

	// cycles since stimulus valid rose, saturating
	always_comb begin
		vcnt_d = 16'h0000;
		if (STIM_VALID_OUT) begin
			vcnt_d = (vcnt_q == 16'hFFFF) ? vcnt_q : vcnt_q + 16'h0001;
		end
	end

	always_ff @(posedge CLK_SYS_IN) begin
		vcnt_q <= RST_B_IN ? vcnt_d : 16'h0000;
	end

	default clocking @(posedge CLK_SYS_IN); endclocking
	default disable iff (!RST_B_IN);

	a_resp_okay: assert property (HRESP_OUT == 1'b0) else $error("bus response not okay");
	a_armed_valid: assert property (ARMED_OUT |-> STIM_VALID_OUT) else $error("armed without valid");
	a_arm_spacing: assert property ($rose(ARMED_OUT) |-> vcnt_q >= ARM_DELAY) else $error("armed too early");
	a_arm_soon: assert property ($rose(STIM_VALID_OUT) |-> ##[1:40] ARMED_OUT) else $error("never armed");
	a_trig_cleared: assert property ($rose(ARMED_OUT) |-> !TRIG_OUT) else $error("trigger not cleared");
	a_trig_armed: assert property ($rose(TRIG_OUT) |-> STIM_VALID_OUT) else $error("trigger while idle");
	a_read_wait: assert property (take && !HWRITE_IN |=> !HREADYOUT_OUT [*2] ##1 HREADYOUT_OUT)
		else $error("read wait wrong");
	a_write_ready: assert property (take && HWRITE_IN |=> HREADYOUT_OUT) else $error("write stalled");
	a_rdata_hold: assert property (!$rose(HREADYOUT_OUT) |-> $stable(HRDATA_OUT)) else $error("read data moved");
	a_stim_hold: assert property (STIM_VALID_OUT && $past(STIM_VALID_OUT) |-> $stable(STIM_OUT))
		else $error("stimulus moved");

	c_armed: cover property ($rose(ARMED_OUT));
	c_trig: cover property ($rose(TRIG_OUT));
	c_read: cover property (take && !HWRITE_IN);
endmodule: ela_trigger_chk

bind ela_trigger_core ela_trigger_chk #(.STIM_W(STIM_W), .ARM_DELAY(ARM_DELAY)) ela_trigger_chk_inst (
	.CLK_SYS_IN(CLK_SYS_IN),
	.RST_B_IN(RST_B_IN),
	.STIM_OUT(STIM_OUT),
	.STIM_VALID_OUT(STIM_VALID_OUT),
	.ARMED_OUT(ARMED_OUT),
	.TRIG_OUT(TRIG_OUT),
	.HSEL_IN(HSEL_IN),
	.HTRANS_IN(HTRANS_IN),
	.HWRITE_IN(HWRITE_IN),
	.HREADY_IN(HREADY_IN),
	.HREADYOUT_OUT(HREADYOUT_OUT),
	.HRDATA_OUT(HRDATA_OUT),
	.HRESP_OUT(HRESP_OUT)
);

`default_nettype wire

// ---- verification/embedded_logic_analyzer_trigger_tb_top.sv ----
/*
 * Testbench: bus tasks arm captures and read back trigger samples.
 * Assumes a counting probe, so each sample value is known.
 */
`timescale 1ns/1ns
`default_nettype none

module embedded_logic_analyzer_trigger_tb_top;
	localparam logic [7:0] PAT = 8'hA5;
	logic clk = 1'b0;
	logic rst_b = 1'b0;
	logic user_clk;
	logic [7:0] probe;
	logic [7:0] trig;
	logic [19:0] stim;
	logic stim_v;
	logic armed;
	logic trg;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h0000_0000;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [2:0] hsize = 3'h2;
	logic [31:0] hwdata = 32'h0000_0000;
	logic hready;
	logic [31:0] hrdata;
	logic hresp;
	logic [31:0] d;
	int bad_count = 0;
	int checks_done = 0;
	int cyc = 0;

	always #25 clk = ~clk;

	user_side_model user_side_model_inst (.user_clk_out(user_clk), .probe_out(probe), .trig_out(trig));

	ela_trigger_core #(.PROBE_W(8), .DEPTH(512), .TRIG_W(8), .STIM_W(20), .ARM_DELAY(16'h0008))
	ela_trigger_core_inst (
		.CLK_SYS_IN(clk), .RST_B_IN(rst_b), .USER_CLK_IN(user_clk), .PROBE_IN(probe),
		.TRIG_IN(trig), .STIM_OUT(stim), .STIM_VALID_OUT(stim_v), .ARMED_OUT(armed),
		.TRIG_OUT(trg), .HSEL_IN(hsel), .HADDR_IN(haddr), .HTRANS_IN(htrans),
		.HWRITE_IN(hwrite), .HSIZE_IN(hsize), .HWDATA_IN(hwdata), .HREADY_IN(hready),
		.HREADYOUT_OUT(hready), .HRDATA_OUT(hrdata), .HRESP_OUT(hresp)
	);

	task automatic final_report();
		$display("checks %0d mismatches %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask: final_report

	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		checks_done++;
		if (g !== e) begin
			bad_count++;
			$display("ERROR %0t mismatch got %h exp %h", $time, g, e);
		end
	endtask: chk

	task automatic bus(input logic is_wr, input logic [7:0] a, input logic [31:0] wd);
		@(posedge clk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= {24'h00_0000, a};
		hwrite <= is_wr;
		do @(posedge clk); while (hready !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge clk); while (hready !== 1'b1);
		d = hrdata;
	endtask: bus

	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		bus(1'b1, a, v);
	endtask: wr

	task automatic rc(input logic [7:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0000_0000);
		chk(d, e);
	endtask: rc

	task automatic cnd(input logic [1:0] c, input logic [5:0] b, input ela_pkg::bit_cond_e k);
		wr(8'h08, {13'h0000, k, 6'h00, c, 2'h0, b});
	endtask: cnd

	task automatic clr();
		for (int c = 0; c < 3; c++) begin
			for (int b = 0; b < 8; b++) begin
				cnd(2'(c), 6'(b), ela_pkg::BC_DONT_CARE);
			end
		end
	endtask: clr

	task automatic wdone();
		int n;
		n = 0;
		d = 32'h0000_0000;
		while (d[4:0] !== 5'h10 && n < 3000) begin
			bus(1'b0, 8'h04, 32'h0000_0000);
			n++;
		end
		chk({27'h000_0000, d[4:0]}, 32'h0000_0010);
	endtask: wdone

	task automatic smp(input logic [8:0] a, input logic [7:0] e);
		wr(8'h14, {23'h00_0000, a});
		rc(8'h18, {24'h00_0000, e});
	endtask: smp

	task automatic cap(input logic [1:0] pre, input logic [1:0] nc, input logic [2:0] am, input logic [7:0] e);
		logic [8:0] a;
		wr(8'h00, {21'h00_0000, am, 2'h0, nc, pre, 2'h1});
		wdone();
		bus(1'b0, 8'h1C, 32'h0000_0000);
		a = d[8:0] + {pre, 7'h00};
		smp(a, e);
		if (pre != 2'h0) begin
			smp(a - 9'h001, e - 8'h01);
		end
		chk({31'h0000_0000, trg}, 32'h0000_0001);
	endtask: cap

	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 90000) begin
			bad_count++;
			final_report();
		end
	end

	initial begin
		repeat (5) @(posedge clk);
		rst_b <= 1'b1;
		rc(8'h04, 32'h0000_0001);
		rc(8'h00, 32'h0000_0110);
		rc(8'h08, 32'h0000_0000);
		rc(8'h20, 32'h0000_0000);
		chk({29'h0000_0000, stim_v, armed, trg}, 32'h0000_0000);
		$display("test registers done");
		wr(8'h0C, 32'h0000_0000);
		wr(8'h10, 32'h000A_BCDE);
		for (int i = 0; i < 8; i++) begin
			cnd(2'h0, 6'(i), PAT[i] ? ela_pkg::BC_LEVEL1 : ela_pkg::BC_LEVEL0);
		end
		cap(2'h1, 2'h1, 3'h1, PAT);
		chk({12'h000, stim}, 32'h000A_BCDE);
		$display("test level and pre-trigger done");
		for (int k = 0; k < 2; k++) begin
			clr();
			cnd(2'h0, 6'd7, (k == 1) ? ela_pkg::BC_FALL : ela_pkg::BC_RISE);
			cap(2'h0, 2'h1, 3'h1, (k == 1) ? 8'h00 : 8'h80);
		end
		$display("test edges done");
		for (int m = 0; m < 2; m++) begin
			clr();
			cnd(2'h0, 6'd7, ela_pkg::BC_FALL);
			cnd(2'h1, 6'd2, ela_pkg::BC_RISE);
			cnd(2'h1, 6'd3, ela_pkg::BC_LEVEL1);
			cnd(2'h2, 6'd7, ela_pkg::BC_LEVEL0);
			cap(2'h0, 2'h3, {1'b1, m == 0, 1'b1}, (m == 1) ? 8'h05 : 8'h0D);
		end
		$display("test sequence done");
		clr();
		wr(8'h00, 32'h0000_0113);
		wdone();
		wr(8'h00, 32'h0000_1112);
		bus(1'b0, 8'h04, 32'h0000_0000);
		chk({27'h000_0000, d[4:0]}, 32'h0000_0002);
		wdone();
		chk({31'h0000_0000, stim_v}, 32'h0000_0001);
		$display("test repeat done");
		final_report();
	end
endmodule: embedded_logic_analyzer_trigger_tb_top

`default_nettype wire
